// >>> lpss_pkg.sv
package lpss_pkg;

	// ==========================================================
	// Port 1 mode field encodings
	localparam logic [2:0] LPSS_MODE_INT_PHY  = 3'h7;
	localparam logic [2:0] LPSS_MODE_MII_PHY  = 3'h1;

	// ==========================================================
	// Strap default values; only the LED function and heartbeat ones are used, when a strap has no pin or does not apply in the port 1 mode
	localparam logic [5:0] LPSS_LED_ENABLE_DEF = 6'h3F;
	localparam logic [1:0] LPSS_LED_FUNC_DEF   = 2'h0;
	localparam logic       LPSS_MANUAL_X_DEF   = 1'h0;
	localparam logic       LPSS_HB_OFF_DEF     = 1'h0;

	// ==========================================================
	// Crossover control selections and pairings
	localparam logic       LPSS_XCTRL_STRAPS  = 1'h0;
	localparam logic       LPSS_PAIR_MDI      = 1'h0;
	localparam logic       LPSS_PAIR_MDIX     = 1'h1;

	// ==========================================================
	// Grouped soft-strap set
	typedef struct packed {
		logic [5:0] led_enable_strap;
		logic [1:0] led_function_strap;
		logic       auto_crossover_strap;
		logic       manual_crossover_strap;
		logic       autoneg_strap;
		logic       port1_heartbeat_test_disable_strap;
	} lpss_straps_type;

	// Register defaults handed to the configuration registers
	typedef struct packed {
		logic [5:0] led_enable_bits;
		logic [1:0] led_function_bits;
		logic       auto_crossover_enable_state;
		logic       autonegotiation_enable_bit;
		logic       heartbeat_test_off_bit;
		logic       crossover_auto;
		logic       crossover_pair;
	} lpss_cfg_type;

	// Loader state, Gray along sample, apply, run and back to apply
	typedef enum logic [1:0] {
		LPSS_ST_SAMPLE = 2'h0,
		LPSS_ST_APPLY  = 2'h1,
		LPSS_ST_RUN    = 2'h3
	} lpss_state_type;

endpackage

// >>> lpss_bit_reg.sv
`timescale 1ns/1ps
// ==========================================================
// One WIDTH-bit register: takes its default on load, else software writes
module lpss_bit_reg #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_default,
	input  wire logic             i_wr,
	input  wire logic [WIDTH-1:0] i_wdata,
	output logic      [WIDTH-1:0] o_q
);
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_q <= '0;
		end else if (i_load) begin
			o_q <= i_default;
		end else if (i_wr) begin
			o_q <= i_wdata;
		end
	end
endmodule // lpss_bit_reg

// >>> lpss_top.sv
`timescale 1ns/1ps
module lpss_top (
	input  wire logic                    i_clk,
	input  wire logic                    i_reset_n,
	input  wire logic [2:0]              i_port1_mode,
	input  wire logic [5:0]              i_led_enable_pin,
	input  wire logic                    i_crossover_strap_led_pin,
	input  wire logic                    i_manual_crossover_pin,
	input  wire logic                    i_autoneg_pin,
	input  wire logic                    i_autoneg_pin_present,
	input  wire logic                    i_heartbeat_pin,
	input  wire logic                    i_eeprom_valid,
	input  wire logic                    i_eeprom_load,
	input  wire lpss_pkg::lpss_straps_type i_eeprom_straps,
	input  wire logic                    i_digital_reset,
	input  wire logic                    i_reload,
	input  wire logic                    i_crossover_control_select,
	input  wire logic                    i_sw_wr,
	input  wire lpss_pkg::lpss_cfg_type  i_sw_wdata,
	output lpss_pkg::lpss_cfg_type       o_cfg,
	output logic                         o_defaults_applied,
	output logic                         o_phy_default_update
);
	import lpss_pkg::*;

	// ==========================================================
	// State
	lpss_state_type  state_q;
	lpss_straps_type latched_q;
	lpss_straps_type active_q;
	lpss_cfg_type    defaults;
	lpss_cfg_type    cfg_q;
	logic            load_q;
	logic            internal_phy;
	logic            an_default;

	assign internal_phy = (i_port1_mode == LPSS_MODE_INT_PHY);
	assign an_default   = i_autoneg_pin_present ? i_autoneg_pin : internal_phy;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= LPSS_ST_SAMPLE;
		end else begin
			unique case (state_q)
				LPSS_ST_SAMPLE: state_q <= LPSS_ST_APPLY;
				LPSS_ST_APPLY:  state_q <= LPSS_ST_RUN;
				LPSS_ST_RUN: begin
					if (i_digital_reset || i_reload || i_eeprom_load) begin
						state_q <= LPSS_ST_APPLY;
					end
				end
				default:        state_q <= LPSS_ST_SAMPLE;
			endcase
		end
	end

	// ==========================================================
	// Pin latch only in the first cycle after reset release
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			latched_q <= '0;
		end else if (state_q == LPSS_ST_SAMPLE) begin
			latched_q.led_enable_strap                   <= i_led_enable_pin;
			latched_q.led_function_strap                 <= LPSS_LED_FUNC_DEF;
			latched_q.auto_crossover_strap               <= i_crossover_strap_led_pin;
			latched_q.manual_crossover_strap             <= i_manual_crossover_pin;
			latched_q.autoneg_strap                      <= an_default;
			latched_q.port1_heartbeat_test_disable_strap <= i_heartbeat_pin;
		end
	end

	// Active set: EEPROM override, or restore of the latched set
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			active_q <= '0;
		end else if (state_q == LPSS_ST_SAMPLE) begin
			active_q.led_enable_strap                   <= i_led_enable_pin;
			active_q.led_function_strap                 <= LPSS_LED_FUNC_DEF;
			active_q.auto_crossover_strap               <= i_crossover_strap_led_pin;
			active_q.manual_crossover_strap             <= i_manual_crossover_pin;
			active_q.autoneg_strap                      <= an_default;
			active_q.port1_heartbeat_test_disable_strap <= i_heartbeat_pin;
		end else if (i_eeprom_load && i_eeprom_valid) begin
			active_q <= i_eeprom_straps;
		end else if ((i_digital_reset || i_reload) && !i_eeprom_valid) begin
			active_q <= latched_q;
		end
	end

	// ==========================================================
	// Default derivation
	always_comb begin
		defaults.led_enable_bits             = active_q.led_enable_strap;
		defaults.led_function_bits           = active_q.led_function_strap;
		defaults.auto_crossover_enable_state = active_q.auto_crossover_strap;
		defaults.autonegotiation_enable_bit  = active_q.autoneg_strap;
		defaults.heartbeat_test_off_bit      = LPSS_HB_OFF_DEF;
		if (i_port1_mode == LPSS_MODE_MII_PHY) begin
			defaults.heartbeat_test_off_bit = active_q.port1_heartbeat_test_disable_strap;
		end
		defaults.crossover_auto = cfg_q.crossover_auto;
		defaults.crossover_pair = cfg_q.crossover_pair;
		// Crossover applies only to the internal PHY
		if (internal_phy && i_crossover_control_select == LPSS_XCTRL_STRAPS) begin
			defaults.crossover_auto = active_q.auto_crossover_strap;
			defaults.crossover_pair = active_q.manual_crossover_strap
				? LPSS_PAIR_MDIX : LPSS_PAIR_MDI;
		end
	end

	// ==========================================================
	// Configuration register bits
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			load_q <= 1'h0;
		end else begin
			load_q <= (state_q == LPSS_ST_APPLY);
		end
	end

	lpss_bit_reg #(
		.WIDTH($bits(lpss_cfg_type))
	) u_cfg (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_load    (state_q == LPSS_ST_APPLY),
		.i_default (defaults),
		.i_wr      (i_sw_wr),
		.i_wdata   (i_sw_wdata),
		.o_q       (cfg_q)
	);

	assign o_cfg = cfg_q;

	// Tells the PHY register logic to refresh speed, duplex, advertisement and mode
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_defaults_applied   <= 1'h0;
			o_phy_default_update <= 1'h0;
		end else begin
			o_defaults_applied   <= load_q || o_defaults_applied;
			o_phy_default_update <= (state_q == LPSS_ST_APPLY);
		end
	end

	// ==========================================================
	// Checks
	sequence s_apply;
		state_q == LPSS_ST_APPLY;
	endsequence

	led_default_load_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_apply ##1 !$past(i_sw_wr) |-> o_cfg.led_enable_bits == $past(active_q.led_enable_strap))
		else $error("LED enable default not loaded");
	led_function_load_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_apply |=> o_cfg.led_function_bits == $past(active_q.led_function_strap))
		else $error("LED function default not loaded");
	xover_state_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_apply |=> o_cfg.auto_crossover_enable_state == $past(active_q.auto_crossover_strap))
		else $error("Crossover state bit wrong");
	xover_pair_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_apply and internal_phy and !i_crossover_control_select
		|=> o_cfg.crossover_pair == $past(active_q.manual_crossover_strap))
		else $error("Crossover pairing wrong");
	xover_ignore_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_apply and !internal_phy and !i_sw_wr |=> $stable(o_cfg.crossover_pair))
		else $error("Crossover strap used outside internal PHY");
	heartbeat_mode_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_apply and i_port1_mode != LPSS_MODE_MII_PHY |=> !o_cfg.heartbeat_test_off_bit)
		else $error("Heartbeat strap used outside MII PHY");
	restore_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_q == LPSS_ST_RUN && (i_digital_reset || i_reload) && !i_eeprom_valid
		|=> active_q == $past(latched_q) && $stable(latched_q))
		else $error("Restore did not use latched straps");
	sw_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_sw_wr && state_q != LPSS_ST_APPLY |=> o_cfg == $past(i_sw_wdata))
		else $error("Software write lost");

	// ==========================================================
	// Request, boot and load checks
	sequence s_request;
		state_q == LPSS_ST_RUN && (i_digital_reset || i_reload || i_eeprom_load);
	endsequence

	sequence s_sample;
		state_q == LPSS_ST_SAMPLE;
	endsequence

	request_apply_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_request |=> s_apply)
		else $error("Reapply request not taken");
	xover_auto_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_apply and internal_phy and !i_crossover_control_select
		|=> o_cfg.crossover_auto == $past(active_q.auto_crossover_strap))
		else $error("Crossover mode wrong");
	autoneg_load_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_apply |=> o_cfg.autonegotiation_enable_bit == $past(active_q.autoneg_strap))
		else $error("Autonegotiation default not loaded");
	autoneg_default_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_sample and !i_autoneg_pin_present |=> latched_q.autoneg_strap == $past(internal_phy))
		else $error("Autonegotiation strap default wrong");
	phy_update_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_apply |=> o_phy_default_update)
		else $error("PHY default update missing");
	phy_pulse_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_phy_default_update |=> !o_phy_default_update)
		else $error("PHY default update longer than one cycle");
	eeprom_override_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_request and i_eeprom_load and i_eeprom_valid |=> active_q == $past(i_eeprom_straps))
		else $error("EEPROM straps not taken");
	strap_latch_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_sample |=> latched_q.led_enable_strap == $past(i_led_enable_pin))
		else $error("Strap pins not latched");
	latch_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_q != LPSS_ST_SAMPLE |=> $stable(latched_q))
		else $error("Latched straps resampled");
	applied_flag_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_apply |=> ##1 o_defaults_applied)
		else $error("Defaults applied flag not set");
endmodule // lpss_top

// >>> lpss_eeprom_model.sv
`timescale 1ns/1ps
// ==========================================================
// Serial EEPROM loader stand-in: a load pulse on every other cycle while go is high
module lpss_eeprom_model (
	input  wire logic                      i_clk,
	input  wire logic                      i_go,
	input  wire logic                      i_present,
	input  wire lpss_pkg::lpss_straps_type i_image,
	output logic                           o_valid,
	output logic                           o_load,
	output lpss_pkg::lpss_straps_type      o_straps
);
	import lpss_pkg::*;
	// Erased part shows inverted image so stale data never looks right
	assign o_valid  = i_present;
	assign o_straps = i_present ? i_image : ~i_image;
	always_ff @(posedge i_clk) begin
		o_load <= i_go & ~o_load;
	end
endmodule // lpss_eeprom_model

// >>> tb_lpss_top.sv
`timescale 1ns/1ps
module tb_lpss_top;
	import lpss_pkg::*;
	logic            clk, rst_n, go, wr, drst, rld, an_p, an, hb, xa, xm, xc, pres;
	logic [2:0]      mode;
	logic [5:0]      led;
	lpss_straps_type img, ee_s;
	lpss_cfg_type    wd, cfg;
	logic            ee_v, ee_ld, app, upd;
	int              error_cnt = 0;
	int              num_checks = 0;
	// ==========================================================
	// Harness
	lpss_eeprom_model u_ee (.i_clk(clk), .i_go(go), .i_present(pres), .i_image(img),
		.o_valid(ee_v), .o_load(ee_ld), .o_straps(ee_s));
	lpss_top u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_port1_mode(mode),
		.i_led_enable_pin(led), .i_crossover_strap_led_pin(xa), .i_manual_crossover_pin(xm),
		.i_autoneg_pin(an), .i_autoneg_pin_present(an_p), .i_heartbeat_pin(hb),
		.i_eeprom_valid(ee_v), .i_eeprom_load(ee_ld), .i_eeprom_straps(ee_s),
		.i_digital_reset(drst), .i_reload(rld), .i_crossover_control_select(xc),
		.i_sw_wr(wr), .i_sw_wdata(wd), .o_cfg(cfg), .o_defaults_applied(app),
		.o_phy_default_update(upd));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string n, input logic [5:0] e, input logic [5:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Reset, set pins, release; returns settled just after edge 2
	task automatic boot(input logic [2:0] m, input logic [5:0] l, input logic a, input logic x,
		input logic c, input logic p);
		@(posedge clk);
		rst_n <= 0;
		mode <= m;
		led <= l;
		xa <= a;
		xm <= x;
		xc <= c;
		an_p <= p;
		an <= 0;
		hb <= 1;
		repeat (12) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_int_phy();
		boot(3'h7, 6'h2A, 0, 1, 0, 0);
		chk("led_en", 6'h2A, cfg.led_enable_bits);
		chk("led_fun", 6'h0, 6'(cfg.led_function_bits));
		chk("auto_state", 6'h0, 6'(cfg.auto_crossover_enable_state));
		chk("x_auto", 6'h0, 6'(cfg.crossover_auto));
		chk("x_pair", 6'(LPSS_PAIR_MDIX), 6'(cfg.crossover_pair));
		chk("an", 6'h1, 6'(cfg.autonegotiation_enable_bit));
		chk("sqe", 6'h0, 6'(cfg.heartbeat_test_off_bit));
		chk("upd", 6'h1, 6'(upd));
		@(posedge clk);
		#1;
		chk("applied", 6'h1, 6'(app));
	endtask
	task automatic t_mii_phy();
		boot(3'h1, 6'h15, 1, 1, 0, 0);
		chk("mii_led", 6'h15, cfg.led_enable_bits);
		chk("auto_state", 6'h1, 6'(cfg.auto_crossover_enable_state));
		chk("x_auto", 6'h0, 6'(cfg.crossover_auto));
		chk("x_pair", 6'h0, 6'(cfg.crossover_pair));
		chk("an", 6'h0, 6'(cfg.autonegotiation_enable_bit));
		chk("sqe", 6'h1, 6'(cfg.heartbeat_test_off_bit));
	endtask
	// Crossover control off straps, autonegotiation pin present and low
	task automatic t_xctrl();
		boot(3'h7, 6'h3F, 1, 1, 1, 1);
		chk("xc_auto", 6'h0, 6'(cfg.crossover_auto));
		chk("xc_pair", 6'h0, 6'(cfg.crossover_pair));
		chk("xc_state", 6'h1, 6'(cfg.auto_crossover_enable_state));
		chk("an_pin", 6'h0, 6'(cfg.autonegotiation_enable_bit));
		chk("xc_led", 6'h3F, cfg.led_enable_bits);
		chk("xc_sqe", 6'h0, 6'(cfg.heartbeat_test_off_bit));
	endtask
	task automatic t_eeprom();
		boot(3'h7, 6'h2A, 0, 0, 0, 0);
		@(posedge clk);
		img <= '{6'h15, 2'h2, 1'h1, 1'h0, 1'h0, 1'h1};
		pres <= 1;
		go <= 1;
		@(posedge clk);
		go <= 0;
		repeat (3) @(posedge clk);
		#1;
		chk("ee_led", 6'h15, cfg.led_enable_bits);
		chk("ee_fun", 6'h2, 6'(cfg.led_function_bits));
		chk("ee_an", 6'h0, 6'(cfg.autonegotiation_enable_bit));
		chk("ee_auto", 6'h1, 6'(cfg.auto_crossover_enable_state));
		chk("ee_xauto", 6'h1, 6'(cfg.crossover_auto));
		chk("ee_pair", 6'(LPSS_PAIR_MDI), 6'(cfg.crossover_pair));
		chk("ee_sqe", 6'h0, 6'(cfg.heartbeat_test_off_bit));
	endtask
	// Digital reset then reload, each with no EEPROM and moved pins
	task automatic t_restore();
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			pres <= 0;
			led <= 6'h3F;
			drst <= (k == 0);
			rld <= (k != 0);
			@(posedge clk);
			drst <= 0;
			rld <= 0;
			@(posedge clk);
			#1;
			chk("restore_led", 6'h2A, cfg.led_enable_bits);
			chk("restore_upd", 6'h1, 6'(upd));
		end
	endtask
	task automatic t_sw();
		@(posedge clk);
		wd <= '{6'h0C, 2'h3, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
		wr <= 1;
		@(posedge clk);
		wr <= 0;
		#1;
		chk("sw_led", 6'h0C, cfg.led_enable_bits);
		chk("sw_an", 6'h0, 6'(cfg.autonegotiation_enable_bit));
		chk("sw_pair", 6'h1, 6'(cfg.crossover_pair));
		chk("sw_fun", 6'h3, 6'(cfg.led_function_bits));
	endtask
	initial begin
		{rst_n, go, wr, drst, rld, an_p, an, hb, xa, xm, xc, pres} = '0;
		mode = 3'h7;
		led = 6'h3F;
		img = '0;
		wd = '0;
		t_int_phy();
		t_mii_phy();
		t_xctrl();
		t_eeprom();
		t_restore();
		t_sw();
		summarize();
	end
	initial begin
		#5000;
		error_cnt++;
		summarize();
	end
endmodule // tb_lpss_top
